/* File: core/adc_frame_alarm_pkg.sv */
// shared constants for the converter frame, conversion and alarm logic
package adc_frame_alarm_pkg;

  // converter resolution and code space
  localparam int RES_BITS      = 14;        // bits per conversion result
  localparam int CODE_STEPS    = 16384;     // codes across full-scale span
  localparam int NUM_CH        = 8;         // analog channels behind the mux
  localparam int CH_BITS       = 3;         // width of a channel number
  localparam int HYST_BITS     = 8;         // width of one hysteresis value
  localparam int CMP_BITS      = 17;        // signed width for alarm limits

  // serial frame layout, counted in falling sclk edges after cs falls
  localparam int CFG_BITS      = 16;        // configuration word length
  localparam int EDGE_LAST_IN  = 16;        // last edge that captures sdi
  localparam int EDGE_FIRST_OUT = 16;       // edge that presents the msb
  localparam int EDGE_CNT_BITS = 6;         // saturating edge counter width
  localparam int OUT_SR_BITS   = 17;        // widest output word

  // configuration word fields
  localparam int CFG_CH_LSB    = 13;        // channel for the next frame
  localparam int CFG_FMT_BIT   = 12;        // output format select
  localparam logic [15:0] CFG_RST = 16'h0000; // configuration after reset

  // output formats: bits shifted out per frame
  localparam logic [4:0] OUT_LEN_DATA = 5'h0e; // result only
  localparam logic [4:0] OUT_LEN_TAG  = 5'h11; // result then channel number

  // alarm limit offsets
  localparam int HI_CLR_OFS    = 2;         // high alarm release margin
  localparam int LO_SET_OFS    = 1;         // low alarm trip margin
  localparam int LO_CLR_OFS    = 1;         // low alarm release margin

  // conversion engine states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_SAMPLE  = 4'h2,
    ST_CONVERT = 4'h4,
    ST_DONE    = 4'h8
  } conv_state_t;

endpackage : adc_frame_alarm_pkg

/* File: core/adc_frame_alarm_logic.sv */
// serial frame, sar conversion engine and per-channel alarm logic
//
// What this block does
// - results are unsigned straight binary codes
// - alarm pin changes only at edge 16
// - alarm high when any channel flag set
// - per channel high/low thresholds and hysteresis
// - high alarm sets above threshold plus hysteresis
// - high alarm clears at threshold-hysteresis-2 or below
// - low alarm sets below threshold-hysteresis-1
// - low alarm clears at threshold+hysteresis+1 or above
// - active flags follow present alarm state
// - tripped flags latch until flag read
// - cs fall samples and starts internal conversion
// - channel comes from previous frame's configuration
// - idle while cs high, no transfer
// - all transfers on falling sclk edges
// - sdi captured msb first on 16 edges
// - new configuration applied at next cs fall
// - sdo driven low through first 15 edges
// - msb at edge 16, then one per edge
// - sdo low after frame, released at cs high
// - output length set by format bit
// - 14-bit lsb available at edge 30
// - sdi ignored after edge 16
`timescale 1ns/1ps
module adc_frame_alarm_logic #(
  parameter int NCH = adc_frame_alarm_pkg::NUM_CH  // channel count
) (
  // system clock and reset (internal oscillator domain)
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  // serial link pins
  input  wire logic                      sclk_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      sdi_i,
  output logic                           sdo_o,
  output logic                           sdo_oe_o,
  output logic                           alarm_o,
  // sar core analog interface
  input  wire logic                      cmp_i,
  output logic                           sample_o,
  output logic [13:0]                    dac_code_o,
  output logic [2:0]                     mux_ch_o,
  output logic                           busy_o,
  // alarm settings, one slice per channel
  input  wire logic [NCH*14-1:0]         hi_thr_i,
  input  wire logic [NCH*8-1:0]          hi_hyst_i,
  input  wire logic [NCH*14-1:0]         lo_thr_i,
  input  wire logic [NCH*8-1:0]          lo_hyst_i,
  // flag register read strobe and flag view
  input  wire logic                      flag_read_i,
  output logic [NCH-1:0]                 hi_active_o,
  output logic [NCH-1:0]                 lo_active_o,
  output logic [NCH-1:0]                 hi_tripped_o,
  output logic [NCH-1:0]                 lo_tripped_o,
  // last result and the configuration in force
  output logic [13:0]                    result_o,
  output logic                           fmt_tag_o
);

  // widen a 14-bit code to the signed comparison width
  function automatic logic signed [16:0] code_ext(input logic [13:0] c);
    code_ext = signed'({3'h0, c});
  endfunction : code_ext

  // widen a hysteresis value to the signed comparison width
  function automatic logic signed [16:0] hyst_ext(input logic [7:0] h);
    hyst_ext = signed'({9'h000, h});
  endfunction : hyst_ext

  // ---------------- link domain (falling sclk) ----------------
  // the counter and shift flops reset while cs is high, so every frame starts clean
  logic                      link_rst_n;    // low while idle or in reset
  logic [5:0]                edge_cnt;      // falling edges seen this frame
  logic [15:0]               cfg_sr;        // incoming configuration bits
  logic [15:0]               cfg_word;      // last complete word, kept over frames
  logic                      cfg_tgl;       // flips once per complete word
  logic [16:0]               out_sr;        // outgoing bits, msb first
  logic [4:0]                out_left;      // bits still to present
  logic                      alarm_s1;      // alarm level sync, first stage
  logic                      alarm_s2;      // alarm level sync, second stage
  logic [16:0]               out_word;      // word loaded at the msb edge
  logic [4:0]                out_len;       // length of that word
  logic                      alarm_any;     // or of every flag, from the system domain

  // cs high forces the link idle with nothing shifted
  assign link_rst_n = rst_n_i & ~cs_n_i;

  // result tag format puts the channel number behind the data bits
  assign out_word = fmt_tag_o ? {result_o, mux_ch_o} : {result_o, 3'h0};
  assign out_len  = fmt_tag_o ? adc_frame_alarm_pkg::OUT_LEN_TAG
                              : adc_frame_alarm_pkg::OUT_LEN_DATA;

  // edge counter, saturates so long frames never wrap
  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      edge_cnt <= 6'h00;
    end else if (edge_cnt != 6'h3f) begin
      edge_cnt <= edge_cnt + 6'h01;
    end
  end

  // configuration shift register, only the first 16 edges are taken
  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cfg_sr <= 16'h0000;
    end else if (edge_cnt < 6'(adc_frame_alarm_pkg::EDGE_LAST_IN)) begin
      cfg_sr <= {cfg_sr[14:0], sdi_i};
    end
    // later edges leave the register alone
  end

  // complete word is held across frames and announced by a toggle
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_word <= adc_frame_alarm_pkg::CFG_RST;
      cfg_tgl  <= 1'b0;
    end else if (!cs_n_i &&
                 edge_cnt == 6'(adc_frame_alarm_pkg::EDGE_LAST_IN - 1)) begin
      cfg_word <= {cfg_sr[14:0], sdi_i};
      cfg_tgl  <= ~cfg_tgl;
    end
  end

  // serial output: low, then msb at edge 16 and one bit per edge, then low to the end
  // the result is loaded without a handshake: the conversion is long
  // finished by edge 16 when the host keeps the sclk rate limit
  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sdo_o    <= 1'b0;
      out_sr   <= 17'h00000;
      out_left <= 5'h00;
    end else if (edge_cnt < 6'(adc_frame_alarm_pkg::EDGE_FIRST_OUT - 1)) begin
      sdo_o <= 1'b0;
    end else if (edge_cnt == 6'(adc_frame_alarm_pkg::EDGE_FIRST_OUT - 1)) begin
      sdo_o    <= out_word[16];
      out_sr   <= {out_word[15:0], 1'b0};
      out_left <= out_len - 5'h01;
    end else if (out_left != 5'h00) begin
      // one further bit per edge; 14 bits end at edge 29, read at 30
      sdo_o    <= out_sr[16];
      out_sr   <= {out_sr[15:0], 1'b0};
      out_left <= out_left - 5'h01;
    end else begin
      sdo_o <= 1'b0;
    end
  end

  // alarm level brought over and shown only at edge 16
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_s1 <= 1'b0;
      alarm_s2 <= 1'b0;
      alarm_o  <= 1'b0;
    end else begin
      alarm_s1 <= alarm_any;
      alarm_s2 <= alarm_s1;
      if (!cs_n_i &&
          edge_cnt == 6'(adc_frame_alarm_pkg::EDGE_FIRST_OUT - 1)) begin
        alarm_o <= alarm_s2;
      end
    end
  end

  // ---------------- system domain ----------------
  logic                      cs_s1;         // cs sync, first stage
  logic                      cs_s2;         // cs sync, second stage
  logic                      cs_s3;         // previous cs level for edge find
  logic                      cs_fall;       // one cycle at frame start
  logic                      tgl_s1;        // cfg toggle sync, first stage
  logic                      tgl_s2;        // cfg toggle sync, second stage
  logic                      tgl_s3;        // previous toggle level
  logic [15:0]               cfg_pend;      // word waiting for next frame
  logic [3:0]                bit_idx;       // sar bit under trial
  logic                      res_new;       // one cycle when a result lands
  logic [13:0]               keep_code;     // trial code after the decision
  adc_frame_alarm_pkg::conv_state_t state;      // engine state
  adc_frame_alarm_pkg::conv_state_t next_state; // engine next state

  assign cs_fall = cs_s3 & ~cs_s2;

  // two-flop sync of cs; third flop only for edge detection
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_s1    <= 1'b1;
      cs_s2    <= 1'b1;
      cs_s3    <= 1'b1;
      sdo_oe_o <= 1'b0;
    end else begin
      cs_s1    <= cs_n_i;
      cs_s2    <= cs_s1;
      cs_s3    <= cs_s2;
      sdo_oe_o <= ~cs_s2;
    end
  end

  // catch each configuration word; it stays put until the next edge 16
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_s1   <= 1'b0;
      tgl_s2   <= 1'b0;
      tgl_s3   <= 1'b0;
      cfg_pend <= adc_frame_alarm_pkg::CFG_RST;
    end else begin
      tgl_s1 <= cfg_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      if (tgl_s2 != tgl_s3) begin
        cfg_pend <= cfg_word;
      end
    end
  end

  // configuration takes effect at the following frame start
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mux_ch_o  <= adc_frame_alarm_pkg::CFG_RST[15:13];
      fmt_tag_o <= adc_frame_alarm_pkg::CFG_RST[12];
    end else if (cs_fall && state == adc_frame_alarm_pkg::ST_IDLE) begin
      mux_ch_o  <= cfg_pend[adc_frame_alarm_pkg::CFG_CH_LSB +: 3];
      fmt_tag_o <= cfg_pend[adc_frame_alarm_pkg::CFG_FMT_BIT];
    end
  end

  // engine state sequencing
  always_comb begin
    next_state = state;
    case (state)
      adc_frame_alarm_pkg::ST_IDLE: begin
        if (cs_fall) begin
          next_state = adc_frame_alarm_pkg::ST_SAMPLE;
        end
      end
      adc_frame_alarm_pkg::ST_SAMPLE: begin
        next_state = adc_frame_alarm_pkg::ST_CONVERT;
      end
      adc_frame_alarm_pkg::ST_CONVERT: begin
        if (bit_idx == 4'h0) begin
          next_state = adc_frame_alarm_pkg::ST_DONE;
        end
      end
      adc_frame_alarm_pkg::ST_DONE: begin
        next_state = adc_frame_alarm_pkg::ST_IDLE;
      end
      default: begin
        next_state = adc_frame_alarm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= adc_frame_alarm_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // trial code with the bit under test dropped when the comparator says low
  assign keep_code = cmp_i ? dac_code_o : (dac_code_o & ~(14'h0001 << bit_idx));

  // successive approximation, one bit per oscillator cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_o   <= 1'b0;
      busy_o     <= 1'b0;
      dac_code_o <= 14'h0000;
      bit_idx    <= 4'h0;
      result_o   <= 14'h0000;
      res_new    <= 1'b0;
    end else begin
      sample_o <= 1'b0;
      res_new  <= 1'b0;
      case (state)
        adc_frame_alarm_pkg::ST_IDLE: begin
          if (cs_fall) begin
            sample_o <= 1'b1;  // hold capacitor takes the channel now
            busy_o   <= 1'b1;
          end
        end
        adc_frame_alarm_pkg::ST_SAMPLE: begin
          dac_code_o <= 14'h2000;  // midscale trial
          bit_idx    <= 4'(adc_frame_alarm_pkg::RES_BITS - 1);
        end
        adc_frame_alarm_pkg::ST_CONVERT: begin
          if (bit_idx == 4'h0) begin
            dac_code_o <= keep_code;
            // code step is span / CODE_STEPS, no sign bit
            result_o   <= keep_code;
            res_new    <= 1'b1;
          end else begin
            dac_code_o <= keep_code | (14'h0001 << (bit_idx - 4'h1));
            bit_idx    <= bit_idx - 4'h1;
          end
        end
        adc_frame_alarm_pkg::ST_DONE: begin
          busy_o <= 1'b0;
        end
        default: begin
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // per-channel alarm comparators, each with its own limits
  for (genvar ch = 0; ch < NCH; ch++) begin : g_alarm
    logic signed [16:0] res_x;     // result, widened
    logic signed [16:0] hi_t;      // high threshold
    logic signed [16:0] hi_h;      // high hysteresis
    logic signed [16:0] lo_t;      // low threshold
    logic signed [16:0] lo_h;      // low hysteresis
    logic               hit;       // result belongs to this channel
    logic               hi_set;    // high trip condition
    logic               hi_clr;    // high release condition
    logic               lo_set;    // low trip condition
    logic               lo_clr;    // low release condition
    logic               next_hi;   // high alarm after this result
    logic               next_lo;   // low alarm after this result

    assign res_x  = code_ext(result_o);
    assign hi_t   = code_ext(hi_thr_i[ch*14 +: 14]);
    assign hi_h   = hyst_ext(hi_hyst_i[ch*8 +: 8]);
    assign lo_t   = code_ext(lo_thr_i[ch*14 +: 14]);
    assign lo_h   = hyst_ext(lo_hyst_i[ch*8 +: 8]);
    assign hit    = res_new && (mux_ch_o == 3'(ch));
    assign hi_set = res_x > (hi_t + hi_h);
    assign hi_clr = res_x <= (hi_t - hi_h - 17'(adc_frame_alarm_pkg::HI_CLR_OFS));
    assign lo_set = res_x < (lo_t - lo_h - 17'(adc_frame_alarm_pkg::LO_SET_OFS));
    assign lo_clr = res_x >= (lo_t + lo_h + 17'(adc_frame_alarm_pkg::LO_CLR_OFS));
    // between the limits the alarm keeps its state, which is the hysteresis
    assign next_hi = hi_set ? 1'b1 : (hi_clr ? 1'b0 : hi_active_o[ch]);
    assign next_lo = lo_set ? 1'b1 : (lo_clr ? 1'b0 : lo_active_o[ch]);

    // active follows, tripped latches; a new trip beats a same-cycle read
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        hi_active_o[ch]  <= 1'b0;
        lo_active_o[ch]  <= 1'b0;
        hi_tripped_o[ch] <= 1'b0;
        lo_tripped_o[ch] <= 1'b0;
      end else begin
        if (hit) begin
          hi_active_o[ch] <= next_hi;
          lo_active_o[ch] <= next_lo;
        end
        if (hit && next_hi) begin
          hi_tripped_o[ch] <= 1'b1;
        end else if (flag_read_i) begin
          hi_tripped_o[ch] <= 1'b0;
        end
        if (hit && next_lo) begin
          lo_tripped_o[ch] <= 1'b1;
        end else if (flag_read_i) begin
          lo_tripped_o[ch] <= 1'b0;
        end
      end
    end
  end

  // one level for the pin; the host then reads the flags
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_any <= 1'b0;
    end else begin
      alarm_any <= |{hi_active_o, lo_active_o, hi_tripped_o, lo_tripped_o};
    end
  end

endmodule : adc_frame_alarm_logic

/* File: test/adc_host_model.sv */
// host serial master model for framed transfers on the link
`timescale 1ns/1ps
module adc_host_model (
  // link pins toward the converter
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  wire logic sdo_pin;  // a released pin shows the inverse, never a stale level
  assign sdo_pin = sdo_oe_i ? sdo_i : ~sdo_i;
  // sclk stands low outside frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end
  // one frame; sdo is sampled half a period before each falling edge
  task automatic xfer(input logic [15:0] word, input int nedge,
                      output logic [16:0] dat, output logic pre, output logic post);
    pre = 1'b0;
    dat = 17'h00000;
    #17 cs_n_o = 1'b0;
    #250;
    for (int k = 1; k <= nedge; k++) begin
      // sdi moves on the rising edge, so it is settled at the falling one
      #62.5 sclk_o = 1'b1;
      sdi_o = (k <= 16) ? word[16-k] : ~sdi_o;
      if (k >= 2 && k <= 16) pre = pre | sdo_pin;
      if (k >= 17) dat = {dat[15:0], sdo_pin};
      #62.5 sclk_o = 1'b0;
    end
    #62.5 post = sdo_pin;
    #62.5 cs_n_o = 1'b1;
    #250;
  endtask : xfer
endmodule : adc_host_model

/* File: test/adc_frame_alarm_properties.sv */
// timing checks on the converter frame, engine and alarm flags
`timescale 1ns/1ps
module adc_frame_alarm_properties #(
  parameter int NCH = 8  // channel count
) (
  // clocks, reset and link pins
  input wire logic           clk_sys_i,
  input wire logic           rst_n_i,
  input wire logic           sclk_i,
  input wire logic           cs_n_i,
  input wire logic           sdo_o,
  input wire logic           sdo_oe_o,
  input wire logic           alarm_o,
  // engine and flags
  input wire logic           sample_o,
  input wire logic [13:0]    dac_code_o,
  input wire logic [2:0]     mux_ch_o,
  input wire logic           busy_o,
  input wire logic           flag_read_i,
  input wire logic [NCH-1:0] hi_active_o,
  input wire logic [NCH-1:0] lo_active_o,
  input wire logic [NCH-1:0] hi_tripped_o,
  input wire logic [NCH-1:0] lo_tripped_o
);
  logic [5:0] edge_cnt;  // falling edges in this frame, cleared while cs is high
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      edge_cnt <= 6'h00;
    end else if (edge_cnt != 6'h3f) begin
      edge_cnt <= edge_cnt + 6'h01;
    end
  end
  // sampled values at a falling edge show what the previous edge launched
  a_alarm_edge: assert property (@(negedge sclk_i) disable iff (!rst_n_i)
    (edge_cnt != 6'h00) && $changed(alarm_o) |-> edge_cnt == 6'h10) else $error("alarm moved");
  a_sdo_quiet: assert property (@(negedge sclk_i) disable iff (!rst_n_i || cs_n_i)
    edge_cnt inside {[6'h01:6'h0f]} |-> !sdo_o) else $error("sdo not low early");
  a_sdo_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cs_n_i && $past(cs_n_i) |-> !sdo_o) else $error("sdo set while idle");
  a_oe_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (!cs_n_i) [*4] |-> sdo_oe_o) else $error("sdo not driven");
  a_oe_release: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cs_n_i [*4] |-> !sdo_oe_o) else $error("sdo not released");
  a_sample_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sample_o |-> !cs_n_i) else $error("sample while idle");
  a_sample_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sample_o |-> busy_o ##1 (!sample_o && dac_code_o == 14'h2000)) else $error("bad start");
  a_busy_span: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(busy_o) |-> busy_o [*8] ##[1:12] !busy_o) else $error("busy length");
  a_mux_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    busy_o && $past(busy_o) |-> $stable(mux_ch_o)) else $error("channel moved");
  a_trip_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (($past(hi_tripped_o) & ~hi_tripped_o) | ($past(lo_tripped_o) & ~lo_tripped_o)) != '0
    |-> $past(flag_read_i)) else $error("tripped cleared");
  a_trip_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ((hi_active_o & ~$past(hi_active_o) & ~hi_tripped_o)
     | (lo_active_o & ~$past(lo_active_o) & ~lo_tripped_o)) == '0) else $error("no trip");
endmodule : adc_frame_alarm_properties

bind adc_frame_alarm_logic adc_frame_alarm_properties #(.NCH(NCH)) u_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .alarm_o(alarm_o), .sample_o(sample_o),
  .dac_code_o(dac_code_o), .mux_ch_o(mux_ch_o), .busy_o(busy_o),
  .flag_read_i(flag_read_i), .hi_active_o(hi_active_o), .lo_active_o(lo_active_o),
  .hi_tripped_o(hi_tripped_o), .lo_tripped_o(lo_tripped_o));

/* File: test/testbench.sv */
// frame, conversion and alarm tests of the converter block
`timescale 1ns/1ps
module testbench;
  localparam int NCH = 8;  // channel count
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b1;  // dropped at time zero, so that reset has an edge
  logic flag_read = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe, alarm, cmp, sample, busy, fmt_tag;
  logic [13:0] dac_code, result;
  logic [2:0] mux_ch;
  logic [NCH*14-1:0] hi_thr, lo_thr;
  logic [NCH*8-1:0] hi_hyst, lo_hyst;
  logic [NCH-1:0] hi_act, lo_act, hi_trp, lo_trp;
  logic [NCH-1:0] m_ha = '0, m_ht = '0, m_la = '0, m_lt = '0;  // expected flags
  logic [13:0] vin [NCH] = '{default: 14'h0000};  // analog level per channel
  logic [2:0] t_ch [12] = '{3'h0, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h5,
                            3'h7, 3'h3};
  logic [13:0] t_v [12] = '{14'h1234, 14'h1f4a, 14'h1f4b, 14'h1f35, 14'h1f34, 14'h03e2,
                            14'h03e1, 14'h03ed, 14'h03ee, 14'h3fff, 14'h0000, 14'h2aaa};
  logic [16:0] dat;
  logic pre, post;
  int err_total = 0, num_checks = 0, cycles = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  assign cmp = (vin[mux_ch] >= dac_code);  // ideal comparator
  // only channel 2 gets reachable limits, the rest can never trip
  initial begin
    for (int c = 0; c < NCH; c++) begin
      hi_thr[c*14+:14] = (c == 2) ? 14'h1f40 : 14'h3fff;
      hi_hyst[c*8+:8] = (c == 2) ? 8'h0a : 8'h00;
      lo_thr[c*14+:14] = (c == 2) ? 14'h03e8 : 14'h0000;
      lo_hyst[c*8+:8] = (c == 2) ? 8'h05 : 8'h00;
    end
  end
  adc_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo),
                         .sdo_oe_i(sdo_oe));
  adc_frame_alarm_logic #(.NCH(NCH)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .alarm_o(alarm), .cmp_i(cmp), .sample_o(sample),
    .dac_code_o(dac_code), .mux_ch_o(mux_ch), .busy_o(busy), .hi_thr_i(hi_thr),
    .hi_hyst_i(hi_hyst), .lo_thr_i(lo_thr), .lo_hyst_i(lo_hyst), .flag_read_i(flag_read),
    .hi_active_o(hi_act), .lo_active_o(lo_act), .hi_tripped_o(hi_trp),
    .lo_tripped_o(lo_trp), .result_o(result), .fmt_tag_o(fmt_tag));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // limits worked out from threshold and hysteresis for the converted channel
  task automatic model(input logic [2:0] c, input int r);
    int t, h;
    t = hi_thr[c*14+:14];
    h = hi_hyst[c*8+:8];
    if (r > t + h) {m_ha[c], m_ht[c]} = 2'h3;
    else if (r <= t - h - 2) m_ha[c] = 1'b0;
    t = lo_thr[c*14+:14];
    h = lo_hyst[c*8+:8];
    if (r < t - h - 1) {m_la[c], m_lt[c]} = 2'h3;
    else if (r >= t + h + 1) m_la[c] = 1'b0;
  endtask : model
  // flag register read, one cycle strobe
  task automatic flag_rd();
    @(posedge clk_sys_i) flag_read <= 1'b1;
    @(posedge clk_sys_i) flag_read <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    m_ht = '0;
    m_lt = '0;
    chk("tripped", {m_ht, m_lt}, {hi_trp, lo_trp});
  endtask : flag_rd
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // a hang is cut short well past the expected run of some 1300 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end
  initial begin
    // an edge on reset at time zero also clears the flops clocked only by sclk
    rst_n_i <= 1'b0;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    // frame i converts t_ch[i] in format i[0], both chosen in frame i-1
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys_i) vin[t_ch[i]] <= t_v[i];
      u_host.xfer({(i < 11) ? t_ch[i+1] : 3'h0, ~i[0], 12'h5a3}, 33,
                  dat, pre, post);
      repeat (4) @(posedge clk_sys_i);
      model(t_ch[i], int'(t_v[i]));
      chk("data", {t_v[i], i[0] ? t_ch[i] : 3'h0}, dat);
      chk("lead", 0, pre);
      chk("tail", 0, post);
      chk("channel", t_ch[i], mux_ch);
      chk("format", i[0], fmt_tag);
      chk("result", t_v[i], result);
      chk("active", {m_ha, m_la}, {hi_act, lo_act});
      chk("tripped", {m_ht, m_lt}, {hi_trp, lo_trp});
      chk("alarm", |{m_ha, m_ht, m_la, m_lt}, alarm);
      chk("oe", 0, sdo_oe);
      if (i == 4) begin
        // flags cleared first, so only a stale pin can still show the alarm
        flag_rd();
        // aborted before edge 16: its word must not be kept, the pin not move
        u_host.xfer(16'he000, 8, dat, pre, post);
        chk("alarm", 1, alarm);
      end
      if (i == 7) flag_rd();
    end
    results();
  end
endmodule : testbench
